//--- hdl/addr_match_pkg.sv
package addr_match_pkg;

  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] OFF_SELECT = 8'h00;
  localparam logic [7:0] OFF_HIGH = 8'h04;
  localparam logic [7:0] OFF_LOW = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;

  // ****************************************
  // field positions
  // ****************************************
  localparam int VALID_BIT = 20;
  localparam int MATCH_BIT = 19;
  localparam int CHAN_MSB = 18;
  localparam int CHAN_LSB = 16;
  localparam int SEL_MSB = 2;
  localparam int GROUP_BIT = 40;
  localparam int HIGH_GROUP_BIT = 0;
  localparam int STAT_KIND_LSB = 8;
  localparam int STAT_ENTRY_LSB = 4;

  // ****************************************
  // sizes and reset values
  // ****************************************
  localparam int ENTRIES = 8;
  localparam logic [2:0] SELECT_RESET = 3'h0;
  localparam logic [31:0] HIGH_RESET = 32'h0000_0000;
  localparam logic [52:0] ENTRY_RESET = 53'h0_0000_0000_0000;

  typedef struct packed {
    logic valid;
    logic match_or_discard_select;
    logic [2:0] channel;
    logic [47:0] station;
  } entry_t;

  typedef enum logic [1:0] {
    RES_NONE = 2'b00,
    RES_MATCH = 2'b01,
    RES_DISCARD = 2'b10
  } result_t;

endpackage

//--- hdl/rx_address_match_table.sv
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns

// Summary of operation
// - only valid entries take part in matching
// - match bit set: entry is a match address
// - match bit clear: entry filters packets out
// - channel field picks one of eight channels
// - channel ignored for filter entries
// - low register holds address bytes 0, 1
// - high register holds address bytes 2 to 5
// - group bit forced zero, reads zero
// - low register write commits the entry
// - address bytes and select reset to zero
module rx_address_match_table
  import addr_match_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // destination address from receive path
  input wire logic rx_addr_valid,
  input wire logic [47:0] rx_dest_addr,
  // match verdict
  output logic rx_result_valid,
  output logic rx_result_match,
  output logic rx_result_discard,
  output logic [2:0] rx_result_channel
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    entry_t [ENTRIES-1:0] table_mem;
    logic [2:0] entry_select;
    logic [31:0] high_stage;
    logic [31:0] rdata;
    logic ready;
    logic slverr;
    logic res_valid;
    result_t res_kind;
    logic res_match;
    logic res_discard;
    logic [2:0] res_channel;
    logic [2:0] res_entry;
  } state_t;

  localparam state_t STATE_RESET = '{
    table_mem: {ENTRIES{ENTRY_RESET}},
    entry_select: SELECT_RESET,
    high_stage: HIGH_RESET,
    rdata: 32'h0000_0000,
    ready: 1'b0,
    slverr: 1'b0,
    res_valid: 1'b0,
    res_kind: RES_NONE,
    res_match: 1'b0,
    res_discard: 1'b0,
    res_channel: 3'h0,
    res_entry: 3'h0
  };

  state_t s_reg;
  state_t s_next;

  logic setup_phase;
  logic write_taken;
  logic hit_select;
  logic hit_high;
  logic hit_low;
  logic hit_status;
  logic mapped;
  entry_t sel_entry;
  logic [31:0] select_view;
  logic [31:0] low_view;
  logic [31:0] status_view;
  logic [47:0] staged_station;
  logic [ENTRIES-1:0] entry_match;
  logic [ENTRIES-1:0] entry_discard;
  logic [ENTRIES-1:0][2:0] entry_chan;
  logic match_hit;
  logic discard_hit;
  logic [2:0] match_chan;
  logic [2:0] match_idx;
  logic [2:0] discard_idx;
  result_t win_kind;
  logic [2:0] win_chan;
  logic [2:0] win_entry;

  // ****************************************
  // per-entry compare
  // ****************************************
  for (genvar g = 0; g < ENTRIES; g++) begin : g_cmp
    entry_compare entry_compare_i (
      .entry(s_reg.table_mem[g]),
      .dest_addr(rx_dest_addr),
      .match_hit(entry_match[g]),
      .discard_hit(entry_discard[g]),
      .hit_channel(entry_chan[g])
    );
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    // ****************************************
    // defaults
    // ****************************************
    s_next = s_reg;

    // ****************************************
    // address decode
    // ****************************************
    hit_select = paddr == OFF_SELECT;
    hit_high = paddr == OFF_HIGH;
    hit_low = paddr == OFF_LOW;
    hit_status = paddr == OFF_STATUS;
    mapped = hit_select || hit_high || hit_low || hit_status;
    setup_phase = psel && !penable;
    write_taken = psel && penable && s_reg.ready && pwrite;

    // ****************************************
    // apb handshake
    // ****************************************
    // ready in the first access cycle, no wait states
    s_next.ready = setup_phase;
    s_next.slverr = setup_phase && !mapped;

    // ****************************************
    // read views
    // ****************************************
    // low reads show the committed entry, not the staged one
    sel_entry = s_reg.table_mem[s_reg.entry_select];
    select_view = 32'h0000_0000;
    select_view[SEL_MSB:0] = s_reg.entry_select;
    low_view = 32'h0000_0000;
    low_view[VALID_BIT] = sel_entry.valid;
    low_view[MATCH_BIT] = sel_entry.match_or_discard_select;
    low_view[CHAN_MSB:CHAN_LSB] = sel_entry.channel;
    low_view[15:8] = sel_entry.station[7:0];
    low_view[7:0] = sel_entry.station[15:8];
    status_view = 32'h0000_0000;
    status_view[STAT_KIND_LSB+1:STAT_KIND_LSB] = s_reg.res_kind;
    status_view[STAT_ENTRY_LSB+2:STAT_ENTRY_LSB] = s_reg.res_entry;
    status_view[2:0] = s_reg.res_channel;

    // ****************************************
    // register read
    // ****************************************
    if (setup_phase) begin
      case (paddr)
        OFF_SELECT: begin
          s_next.rdata = select_view;
        end
        OFF_HIGH: begin
          s_next.rdata = s_reg.high_stage;
        end
        OFF_LOW: begin
          s_next.rdata = low_view;
        end
        OFF_STATUS: begin
          s_next.rdata = status_view;
        end
        default: begin
          s_next.rdata = 32'h0000_0000;
        end
      endcase
    end

    // ****************************************
    // staged entry
    // ****************************************
    // bytes in wire order, group bit cleared
    staged_station[47:40] = s_reg.high_stage[7:0];
    staged_station[39:32] = s_reg.high_stage[15:8];
    staged_station[31:24] = s_reg.high_stage[23:16];
    staged_station[23:16] = s_reg.high_stage[31:24];
    staged_station[15:8] = pwdata[7:0];
    staged_station[7:0] = pwdata[15:8];
    staged_station[GROUP_BIT] = 1'b0;

    // ****************************************
    // register write, at the access edge only
    // ****************************************
    if (write_taken) begin
      case (paddr)
        OFF_SELECT: begin
          s_next.entry_select = pwdata[SEL_MSB:0];
        end
        OFF_HIGH: begin
          // staged only, no table change
          s_next.high_stage = pwdata;
          s_next.high_stage[HIGH_GROUP_BIT] = 1'b0;
        end
        OFF_LOW: begin
          // commit the full 53-bit entry
          s_next.table_mem[s_reg.entry_select].valid =
            pwdata[VALID_BIT];
          s_next.table_mem[s_reg.entry_select].match_or_discard_select =
            pwdata[MATCH_BIT];
          s_next.table_mem[s_reg.entry_select].channel =
            pwdata[CHAN_MSB:CHAN_LSB];
          s_next.table_mem[s_reg.entry_select].station = staged_station;
        end
        default: begin
        end
      endcase
    end

    // ****************************************
    // address compare
    // ****************************************
    match_hit = 1'b0;
    discard_hit = 1'b0;
    match_chan = 3'h0;
    match_idx = 3'h0;
    discard_idx = 3'h0;
    // walk down so the lowest index is left
    for (int i = ENTRIES - 1; i >= 0; i--) begin
      if (entry_match[i]) begin
        match_hit = 1'b1;
        match_chan = entry_chan[i];
        match_idx = 3'(i);
      end
      if (entry_discard[i]) begin
        discard_hit = 1'b1;
        discard_idx = 3'(i);
      end
    end

    // ****************************************
    // priority: any filter hit discards
    // ****************************************
    if (discard_hit) begin
      win_kind = RES_DISCARD;
      win_chan = 3'h0;
      win_entry = discard_idx;
    end else if (match_hit) begin
      win_kind = RES_MATCH;
      win_chan = match_chan;
      win_entry = match_idx;
    end else begin
      win_kind = RES_NONE;
      win_chan = 3'h0;
      win_entry = 3'h0;
    end

    // ****************************************
    // verdict, flagged for one cycle
    // ****************************************
    s_next.res_valid = 1'b0;
    if (rx_addr_valid) begin
      s_next.res_valid = 1'b1;
      s_next.res_kind = win_kind;
      s_next.res_match = win_kind == RES_MATCH;
      s_next.res_discard = win_kind == RES_DISCARD;
      s_next.res_channel = win_chan;
      s_next.res_entry = win_entry;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s_reg <= STATE_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign prdata = s_reg.rdata;
  assign pready = s_reg.ready;
  assign pslverr = s_reg.slverr;
  assign rx_result_valid = s_reg.res_valid;
  assign rx_result_match = s_reg.res_match;
  assign rx_result_discard = s_reg.res_discard;
  assign rx_result_channel = s_reg.res_channel;

endmodule // rx_address_match_table

// ****************************************
// one entry against the frame address
// ****************************************
module entry_compare
  import addr_match_pkg::*;
#(
  parameter int ADDR_BYTES = 6
)
(
  // stored entry
  input wire entry_t entry,
  // frame destination address
  input wire logic [47:0] dest_addr,
  // hit flags
  output logic match_hit,
  output logic discard_hit,
  output logic [2:0] hit_channel
);

  logic [ADDR_BYTES-1:0] byte_same;
  logic same_addr;
  logic entry_live;

  // ****************************************
  // byte compare
  // ****************************************
  for (genvar b = 0; b < ADDR_BYTES; b++) begin : g_byte
    assign byte_same[b] = entry.station[8*b +: 8] == dest_addr[8*b +: 8];
  end

  // ****************************************
  // hit flags
  // ****************************************
  always_comb begin
    entry_live = entry.valid;
    same_addr = &byte_same;
    match_hit = entry_live && same_addr &&
                entry.match_or_discard_select;
    discard_hit = entry_live && same_addr &&
                  !entry.match_or_discard_select;
    // a filter entry never steers
    hit_channel = entry.match_or_discard_select ? entry.channel : 3'h0;
  end

endmodule // entry_compare

//--- tb/rx_address_match_table_properties.sv
`timescale 1ns/1ns
module rx_address_match_table_properties
  import addr_match_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // verdict
  input wire logic rx_addr_valid,
  input wire logic rx_result_valid,
  input wire logic rx_result_match,
  input wire logic rx_result_discard,
  input wire logic [2:0] rx_result_channel
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // ****************
  // properties
  // ****************
  property p_rdy; psel && !penable |=> pready && penable; endproperty
  a_rdy: assert property (p_rdy) else $error("ready late");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready long");
  property p_err; pslverr |-> pready && prdata == 32'h0000_0000; endproperty
  a_err: assert property (p_err) else $error("bad error");
  property p_lat; rx_addr_valid |=> rx_result_valid; endproperty
  a_lat: assert property (p_lat) else $error("verdict late");
  property p_cause; rx_result_valid |-> $past(rx_addr_valid); endproperty
  a_cause: assert property (p_cause) else $error("stray verdict");
  property p_excl; !(rx_result_match && rx_result_discard); endproperty
  a_excl: assert property (p_excl) else $error("both kinds");
  property p_dchan; rx_result_discard |-> rx_result_channel == 3'h0; endproperty
  a_dchan: assert property (p_dchan) else $error("discard channel");
  property p_hold;
    !rx_result_valid |-> $stable({rx_result_match, rx_result_discard, rx_result_channel});
  endproperty
  a_hold: assert property (p_hold) else $error("verdict moved");
  property p_grp; pready && !pwrite && paddr == OFF_HIGH |-> !prdata[HIGH_GROUP_BIT]; endproperty
  a_grp: assert property (p_grp) else $error("group bit set");
  property p_lres; pready && !pwrite && paddr == OFF_LOW |-> prdata[31:21] == 11'h000; endproperty
  a_lres: assert property (p_lres) else $error("low reserved");
endmodule // rx_address_match_table_properties

//--- tb/tb_rx_address_match_table.sv
`timescale 1ns/1ns
`define CHK(n, x, g) begin n_tests++; if ((g) !== (x)) begin bad_count++; \
  $display("Error %s expected %0h seen %0h", n, x, g); end end
module tb_rx_address_match_table
  import addr_match_pkg::*;
();
  logic mclk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, rx_addr_valid = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, r;
  logic [47:0] rx_dest_addr = 48'h0000_0000_0000;
  logic pready, pslverr, e, rx_result_valid, rx_result_match, rx_result_discard;
  logic [2:0] rx_result_channel;
  int bad_count = 0, n_tests = 0;
  always #4 mclk = ~mclk;
  rx_address_match_table rx_address_match_table_i (.*);
  // ****************
  // access tasks
  // ****************
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0000_0000);
    `CHK("prdata", x, r)
  endtask
  task prog(input logic [2:0] i, input logic [31:0] h, input logic [31:0] l);
    apb(1'b1, OFF_SELECT, {29'h0, i});
    apb(1'b1, OFF_HIGH, h);
    apb(1'b1, OFF_LOW, l);
  endtask
  task look(input logic [47:0] a, input logic m, input logic d, input logic [2:0] c);
    @(posedge mclk);
    rx_addr_valid <= 1'b1;
    rx_dest_addr <= a;
    @(posedge mclk);
    rx_addr_valid <= 1'b0;
    @(posedge mclk);
    `CHK("verdict", {1'b1, m, d, c}, {rx_result_valid, rx_result_match, rx_result_discard,
      rx_result_channel})
  endtask
  task conclude();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ****************
  // tests
  // ****************
  initial begin
    repeat (16) @(posedge mclk);
    reset_n <= 1'b1;
    rdc(OFF_SELECT, 32'h0000_0000);
    rdc(OFF_HIGH, 32'h0000_0000);
    rdc(OFF_LOW, 32'h0000_0000);
    for (int i = 0; i < ENTRIES; i++) begin
      prog(3'(i), 32'h0000_0000, 32'h0000_0000);
    end
    $display("test reset done");
    prog(3'h2, 32'h1122_3345, 32'h001D_AABB);
    rdc(OFF_HIGH, 32'h1122_3344);
    rdc(OFF_LOW, 32'h001D_AABB);
    look(48'h4433_2211_BBAA, 1'b1, 1'b0, 3'h5);
    look(48'h4533_2211_BBAA, 1'b0, 1'b0, 3'h0);
    $display("test program done");
    apb(1'b1, OFF_SELECT, 32'h0000_0003);
    apb(1'b1, OFF_HIGH, 32'hFFFF_FF00);
    rdc(OFF_LOW, 32'h0000_0000);
    look(48'h00FF_FFFF_0201, 1'b0, 1'b0, 3'h0);
    apb(1'b1, OFF_LOW, 32'h0017_0102);
    look(48'h00FF_FFFF_0201, 1'b0, 1'b1, 3'h0);
    apb(1'b1, OFF_LOW, 32'h0007_0102);
    look(48'h00FF_FFFF_0201, 1'b0, 1'b0, 3'h0);
    $display("test staging done");
    for (int c = 0; c < 8; c++) begin
      prog(3'h2, 32'h1122_3345, {13'h0003, 3'(c), 16'hAABB});
      look(48'h4433_2211_BBAA, 1'b1, 1'b0, 3'(c));
    end
    prog(3'h4, 32'h1122_3345, 32'h0010_AABB);
    look(48'h4433_2211_BBAA, 1'b0, 1'b1, 3'h0);
    rdc(OFF_STATUS, 32'h0000_0240);
    rdc(OFF_SELECT, 32'h0000_0004);
    apb(1'b0, 8'h10, 32'h0000_0000);
    `CHK("slverr", 33'h1_0000_0000, {e, r})
    $display("test channels done");
    conclude();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    conclude();
  end
endmodule // tb_rx_address_match_table
bind rx_address_match_table rx_address_match_table_properties
  rx_address_match_table_properties_i (.*);
